// ### usbhc_pkg.sv
`default_nettype none
package usbhc_pkg;
	// ==========================================
	// Timing
	localparam int CLK_MHZ = 50;
	localparam int LONG_MS = 10;
	localparam int LONG_CYC = LONG_MS * 1000 * CLK_MHZ;
	localparam int LNK_HALF = 4;
	localparam int NEP = 14;
	// ==========================================
	// Link transfer kinds
	localparam logic [1:0] K_IDLE = 2'h0;
	localparam logic [1:0] K_OP = 2'h1;
	localparam logic [1:0] K_WR = 2'h2;
	localparam logic [1:0] K_RD = 2'h3;
	// ==========================================
	// Opcodes
	localparam logic [7:0] OP_EP_LAST = 8'h0D;
	localparam logic [7:0] OP_STALL_LO = 8'h40;
	localparam logic [7:0] OP_STALL_HI = 8'h4D;
	localparam logic [7:0] OP_PORT = 8'hE0;
	localparam logic [7:0] OP_PORT_MASK = 8'hF6;
	localparam logic [7:0] OP_STS_MASK = 8'hFE;
	localparam logic [7:0] OP_ACK_SETUP = 8'hF1;
	localparam logic [7:0] OP_CLR_BUF = 8'hF2;
	localparam logic [7:0] OP_FRAME = 8'hF5;
	localparam logic [7:0] OP_RESUME = 8'hF6;
	localparam logic [7:0] OP_CHG_BITS = 8'hF7;
	localparam logic [7:0] OP_VALIDATE = 8'hFA;
	// ==========================================
	// Feature codes
	localparam logic [2:0] FEAT_PORT_ENABLE = 3'h0;
	localparam logic [2:0] FEAT_PORT_SUSPEND = 3'h1;
	localparam logic [2:0] FEAT_PORT_RESTART = 3'h2;
	localparam logic [2:0] FEAT_PORT_POWER = 3'h3;
	localparam logic [2:0] FEAT_C_OVERCUR = 3'h7;
	// ==========================================
	// Status and change byte bit positions
	localparam int B_CONN = 0;
	localparam int B_EN = 1;
	localparam int B_SUSP = 2;
	localparam int B_OC = 3;
	localparam int B_RST = 4;
	localparam int B_PWR = 5;
	localparam int B_LS = 6;
	localparam int B_LPCHG = 0;
	localparam int B_EFCHG = 1;
	// ==========================================
	// Controller register map
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_WDATA = 8'h04;
	localparam logic [7:0] A_RDATA = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0C;
	localparam logic [7:0] A_EMB = 8'h10;
	localparam int EMB_SET = 3;
	localparam int EMB_BABBLE = 4;
	typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL} usbhc_hst_t;
endpackage
`default_nettype wire

// ### usbhc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface usbhc_link_if;
	logic clk;
	logic [1:0] kind;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport dev(input clk, input kind, input wdata, output rdata);
	modport ctl(output clk, output kind, output wdata, input rdata);
endinterface // usbhc_link_if
`default_nettype wire

// ### usbhc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module usbhc_sync #(parameter int W = 1) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_ff <= '0;
			s2_ff <= '0;
		end else begin
			s1_ff <= d_i;
			s2_ff <= s1_ff;
		end
	end
	assign q_o = s2_ff;
endmodule // usbhc_sync
`default_nettype wire

// ### usbhc_dev.sv
// Function
// - Full OUT buffer NAKs until freed
// - Clear-buffer command frees buffer for new packets
// - Validate command FAh marks IN buffer full
// - Write after 40-4Dh sets endpoint stall
// - SETUP token unstalls a stalled control endpoint
// - Unstall or zero write re-initialises endpoint
// - SETUP flushes control IN, blocks validate and clear
// - F1h on both control endpoints unblocks
// - E0-E1h clear, E8-E9h set port feature
// - Feature codes: enable, suspend, reset, power, changes
// - Mode 0: power and overcurrent change shared
// - Mode 1: power per port, overcurrent change shared
// - Power set: first power, second overcurrent detect
// - E0-E1h reads: status then change byte
// - Status byte bits; low speed needs connect
// - Reset bit reads one for reset duration
// - Change bits stick until feature clear
// - F7h write: local power, embedded change bits
// - F6h or downstream event drives timed resume
// - F5h reads frame number, low byte first
// - Babble disables embedded function; controller records it
// - Controller emulates embedded port reset
`timescale 1ns/1ps
`default_nettype none
module usbhc_dev
	import usbhc_pkg::*;
#(
	parameter int unsigned RST_CYC = LONG_CYC
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RESETN_I,
	// Controller link
	usbhc_link_if.dev LNK,
	// Packet engine events
	input wire logic [NEP-1:0] OUT_PKT_I,
	input wire logic [NEP-1:0] IN_SENT_I,
	input wire logic SETUP_RX_I,
	input wire logic SOF_OK_I,
	input wire logic [10:0] FRAME_I,
	input wire logic BABBLE_I,
	input wire logic MODE_I,
	// Downstream pins
	input wire logic [1:0] CONN_I,
	input wire logic [1:0] LS_I,
	input wire logic [1:0] OC_I,
	// Endpoint state
	output logic [NEP-1:0] BUF_FULL_O,
	output logic [NEP-1:0] STALL_O,
	output logic [NEP-1:0] TOGGLE_O,
	output logic SETUP_HOLD_O,
	// Port and hub state
	output logic [1:0] PORT_EN_O,
	output logic [1:0] PORT_SUSP_O,
	output logic [1:0] PORT_RST_O,
	output logic [1:0] OC_DET_O,
	output logic POWER_O,
	output logic RESUME_O,
	output logic EF_DIS_O,
	output logic [3:0] HUB_CHG_O
);
	// ==========================================
	// Link capture
	logic [10:0] lnk_s;
	logic [1:0] pin_c;
	logic [1:0] pin_l;
	logic [1:0] pin_o;
	logic clk_d_ff;
	logic ev;
	logic [1:0] kind;
	logic [7:0] wd;
	usbhc_sync #(.W(17)) u_sync (
		.clk_i(CLOCK_I),
		.rstn_i(RESETN_I),
		.d_i({LNK.clk, LNK.kind, LNK.wdata, CONN_I, LS_I, OC_I}),
		.q_o({lnk_s, pin_c, pin_l, pin_o})
	);
	assign kind = lnk_s[9:8];
	assign wd = lnk_s[7:0];
	assign ev = lnk_s[10] & ~clk_d_ff;
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			clk_d_ff <= 1'b0;
		end else begin
			clk_d_ff <= lnk_s[10];
		end
	end
	// ==========================================
	// Command phase
	logic [7:0] op_ff;
	logic [1:0] idx_ff;
	logic is_op;
	logic is_wr;
	logic is_rd;
	logic first_wr;
	assign is_op = ev & (kind == K_OP);
	assign is_wr = ev & (kind == K_WR);
	assign is_rd = ev & (kind == K_RD);
	assign first_wr = is_wr & (idx_ff == 2'h0);
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			op_ff <= 8'h00;
			idx_ff <= 2'h0;
		end else if (is_op) begin
			op_ff <= wd;
			idx_ff <= 2'h0;
		end else if ((is_wr | is_rd) && idx_ff != 2'h3) begin
			idx_ff <= idx_ff + 2'h1;
		end
	end
	// ==========================================
	// Endpoint commands
	logic [3:0] sel_ff;
	logic lock_ff;
	logic [1:0] ack_ff;
	logic val_cmd;
	logic clr_cmd;
	logic stall_wr;
	logic [NEP-1:0] full_ff;
	logic [NEP-1:0] stall_ff;
	logic [NEP-1:0] tog_ff;
	logic [NEP-1:0] reinit;
	assign val_cmd = is_op & (wd == OP_VALIDATE) & ~lock_ff;
	assign clr_cmd = is_op & (wd == OP_CLR_BUF) & ~lock_ff;
	assign stall_wr = first_wr & (op_ff >= OP_STALL_LO) & (op_ff <= OP_STALL_HI);
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			sel_ff <= 4'h0;
		end else if (is_op && wd <= OP_EP_LAST) begin
			sel_ff <= wd[3:0];
		end
	end
	// Setup wins so a late acknowledge cannot release a fresh setup
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			lock_ff <= 1'b0;
			ack_ff <= 2'h0;
		end else if (SETUP_RX_I) begin
			lock_ff <= 1'b1;
			ack_ff <= 2'h0;
		end else begin
			if (is_op && wd == OP_ACK_SETUP && sel_ff[3:1] == 3'h0) begin
				ack_ff[sel_ff[0]] <= 1'b1;
			end
			if (&ack_ff) begin
				lock_ff <= 1'b0;
			end
		end
	end
	// Even entries are OUT buffers, odd entries IN buffers
	for (genvar e = 0; e < NEP; e++) begin : g_ep
		assign reinit[e] = (stall_wr & (op_ff[3:0] == 4'(e)) & ~wd[0])
			| (SETUP_RX_I & (e < 2) & stall_ff[e]);
		always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
			if (!RESETN_I) begin
				full_ff[e] <= 1'b0;
			end else begin
				if (reinit[e] | (clr_cmd & (sel_ff == 4'(e)))
					| ((e % 2 == 1) & IN_SENT_I[e]) | ((e == 1) & SETUP_RX_I)) begin
					full_ff[e] <= 1'b0;
				end
				if (((e % 2 == 0) & OUT_PKT_I[e])
					| ((e % 2 == 1) & val_cmd & (sel_ff == 4'(e)))) begin
					full_ff[e] <= 1'b1;
				end
			end
		end
		always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
			if (!RESETN_I) begin
				stall_ff[e] <= 1'b0;
			end else if (stall_wr && op_ff[3:0] == 4'(e)) begin
				stall_ff[e] <= wd[0];
			end else if (SETUP_RX_I && e < 2) begin
				stall_ff[e] <= 1'b0;
			end
		end
		always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
			if (!RESETN_I) begin
				tog_ff[e] <= 1'b0;
			end else if (reinit[e]) begin
				tog_ff[e] <= 1'b0;
			end else if (OUT_PKT_I[e] | IN_SENT_I[e]) begin
				tog_ff[e] <= ~tog_ff[e];
			end
		end
	end
	// ==========================================
	// Downstream ports
	logic port_wr;
	logic fset;
	logic [2:0] code;
	logic [1:0] conn_d_ff;
	logic [1:0] oc_d_ff;
	logic [1:0] en_ff;
	logic [1:0] susp_ff;
	logic [1:0] rst_ff;
	logic [1:0] pwr_ff;
	logic [1:0] ocd_ff;
	logic [1:0] oc_act;
	logic [1:0] conn_ev;
	logic [4:0] chg_ff [2];
	logic [7:0] sts [2];
	assign port_wr = first_wr & ((op_ff & OP_PORT_MASK) == OP_PORT) & (wd[7:3] == 5'h0);
	assign fset = op_ff[3];
	assign code = wd[2:0];
	for (genvar p = 0; p < 2; p++) begin : g_port
		logic hit;
		logic phit;
		logic rdone;
		logic [19:0] rcnt_ff;
		logic [4:0] cset;
		logic [4:0] cclr;
		assign hit = port_wr & (op_ff[0] == 1'(p));
		// Only one switch, but mode 1 tracks power per port
		assign phit = port_wr & (~MODE_I | (op_ff[0] == 1'(p)));
		assign oc_act[p] = ocd_ff[p] & (MODE_I ? pin_o[p] : pin_o[0]);
		assign conn_ev[p] = pin_c[p] ^ conn_d_ff[p];
		assign rdone = rst_ff[p] & (rcnt_ff == 20'h0);
		always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
			if (!RESETN_I) begin
				conn_d_ff[p] <= 1'b0;
				oc_d_ff[p] <= 1'b0;
			end else begin
				conn_d_ff[p] <= pin_c[p];
				oc_d_ff[p] <= oc_act[p];
			end
		end
		always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
			if (!RESETN_I) begin
				en_ff[p] <= 1'b0;
				susp_ff[p] <= 1'b0;
			end else if (conn_ev[p] & ~pin_c[p]) begin
				en_ff[p] <= 1'b0;
				susp_ff[p] <= 1'b0;
			end else if (rdone) begin
				en_ff[p] <= 1'b1;
			end else if (hit && code == FEAT_PORT_ENABLE) begin
				en_ff[p] <= fset;
			end else if (hit && code == FEAT_PORT_SUSPEND) begin
				susp_ff[p] <= fset;
			end
		end
		always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
			if (!RESETN_I) begin
				rst_ff[p] <= 1'b0;
				rcnt_ff <= 20'h0;
			end else if (hit && fset && code == FEAT_PORT_RESTART) begin
				rst_ff[p] <= 1'b1;
				rcnt_ff <= 20'(RST_CYC - 1);
			end else if (rdone) begin
				rst_ff[p] <= 1'b0;
			end else if (rst_ff[p]) begin
				rcnt_ff <= rcnt_ff - 20'h1;
			end
		end
		// Detection trails power so the inrush surge is not flagged
		always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
			if (!RESETN_I) begin
				pwr_ff[p] <= 1'b0;
				ocd_ff[p] <= 1'b0;
			end else if (phit && code == FEAT_PORT_POWER) begin
				if (!fset) begin
					pwr_ff[p] <= 1'b0;
					ocd_ff[p] <= 1'b0;
				end else if (!pwr_ff[p]) begin
					pwr_ff[p] <= 1'b1;
				end else begin
					ocd_ff[p] <= 1'b1;
				end
			end
		end
		assign cset = {rdone, oc_act[p] ^ oc_d_ff[p],
			hit & ~fset & (code == FEAT_PORT_SUSPEND) & susp_ff[p],
			conn_ev[p] & ~pin_c[p] & en_ff[p], conn_ev[p]};
		assign cclr = {hit & ~fset & (code == FEAT_PORT_RESTART),
			port_wr & ~fset & (code == FEAT_C_OVERCUR),
			hit & ~fset & (code == 3'h6), hit & ~fset & (code == 3'h5),
			hit & ~fset & (code == 3'h4)};
		// Set wins over a clear in the same cycle
		always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
			if (!RESETN_I) begin
				chg_ff[p] <= 5'h0;
			end else begin
				chg_ff[p] <= (chg_ff[p] & ~cclr) | cset;
			end
		end
		always_comb begin
			sts[p] = 8'h00;
			sts[p][B_CONN] = pin_c[p];
			sts[p][B_EN] = en_ff[p];
			sts[p][B_SUSP] = susp_ff[p];
			sts[p][B_OC] = oc_act[p];
			sts[p][B_RST] = rst_ff[p];
			sts[p][B_PWR] = |pwr_ff;
			sts[p][B_LS] = pin_l[p] & pin_c[p];
		end
	end
	// ==========================================
	// Hub level state
	logic [1:0] chgbits_ff;
	logic [10:0] frame_ff;
	logic res_ff;
	logic [19:0] res_cnt_ff;
	logic ef_dis_ff;
	logic pwr_o_ff;
	logic [3:0] hub_chg_ff;
	logic res_go;
	assign res_go = (is_op & (wd == OP_RESUME)) | (|conn_ev);
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			chgbits_ff <= 2'h0;
		end else if (first_wr && op_ff == OP_CHG_BITS) begin
			chgbits_ff <= {wd[B_EFCHG], wd[B_LPCHG]};
		end
	end
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			res_ff <= 1'b0;
			res_cnt_ff <= 20'h0;
		end else if (res_go && !res_ff) begin
			res_ff <= 1'b1;
			res_cnt_ff <= 20'(RST_CYC - 1);
		end else if (res_ff && res_cnt_ff == 20'h0) begin
			res_ff <= 1'b0;
		end else if (res_ff) begin
			res_cnt_ff <= res_cnt_ff - 20'h1;
		end
	end
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			frame_ff <= 11'h000;
		end else if (SOF_OK_I) begin
			frame_ff <= FRAME_I;
		end
	end
	// Stays off until the controller reports the embedded change
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ef_dis_ff <= 1'b0;
		end else if (BABBLE_I) begin
			ef_dis_ff <= 1'b1;
		end else if (first_wr && op_ff == OP_CHG_BITS && wd[B_EFCHG]) begin
			ef_dis_ff <= 1'b0;
		end
	end
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pwr_o_ff <= 1'b0;
			hub_chg_ff <= 4'h0;
		end else begin
			pwr_o_ff <= |pwr_ff;
			hub_chg_ff <= {|chg_ff[1], |chg_ff[0], chgbits_ff};
		end
	end
	// ==========================================
	// Read data
	logic [7:0] rd_ff;
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rd_ff <= 8'h00;
		end else if (is_rd) begin
			if (op_ff <= OP_EP_LAST) begin
				rd_ff <= {7'h00, full_ff[op_ff[3:0]]};
			end else if ((op_ff & OP_STS_MASK) == OP_PORT) begin
				rd_ff <= (idx_ff == 2'h0) ? sts[op_ff[0]]
					: (idx_ff == 2'h1) ? {3'h0, chg_ff[op_ff[0]]} : 8'h00;
			end else if (op_ff == OP_FRAME) begin
				rd_ff <= (idx_ff == 2'h0) ? frame_ff[7:0]
					: (idx_ff == 2'h1) ? {5'h00, frame_ff[10:8]} : 8'h00;
			end else begin
				rd_ff <= 8'h00;
			end
		end
	end
	assign LNK.rdata = rd_ff;
	assign BUF_FULL_O = full_ff;
	assign STALL_O = stall_ff;
	assign TOGGLE_O = tog_ff;
	assign SETUP_HOLD_O = lock_ff;
	assign PORT_EN_O = en_ff;
	assign PORT_SUSP_O = susp_ff;
	assign PORT_RST_O = rst_ff;
	assign OC_DET_O = ocd_ff;
	assign POWER_O = pwr_o_ff;
	assign RESUME_O = res_ff;
	assign EF_DIS_O = ef_dis_ff;
	assign HUB_CHG_O = hub_chg_ff;
endmodule // usbhc_dev
`default_nettype wire

// ### usbhc_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module usbhc_ctl
	import usbhc_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RESETN_I,
	// Software port
	input wire logic [7:0] ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [15:0] RDATA_O,
	// Embedded function control
	output logic EF_EN_O,
	output logic EF_ADDR0_O,
	output logic INT_EP_DIS_O,
	// Link to the hub
	usbhc_link_if.ctl LNK
);
	// ==========================================
	// Link sequencer
	usbhc_hst_t st_ff;
	logic [2:0] cnt_ff;
	logic clk_ff;
	logic [1:0] kind_ff;
	logic [7:0] wd_ff;
	logic [7:0] rbyte_ff;
	logic [7:0] rd_s;
	logic go;
	assign go = WR_I & (st_ff == H_IDLE)
		& ((ADDR_I == A_CMD) | (ADDR_I == A_WDATA) | (ADDR_I == A_RDATA));
	usbhc_sync #(.W(8)) u_sync (
		.clk_i(CLOCK_I),
		.rstn_i(RESETN_I),
		.d_i(LNK.rdata),
		.q_o(rd_s)
	);
	// Fields change only while the link clock is low
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			st_ff <= H_IDLE;
			cnt_ff <= 3'h0;
			clk_ff <= 1'b0;
			kind_ff <= K_IDLE;
			wd_ff <= 8'h00;
			rbyte_ff <= 8'h00;
		end else begin
			case (st_ff)
				H_IDLE: begin
					if (go) begin
						st_ff <= H_LOW;
						cnt_ff <= 3'(LNK_HALF - 1);
						wd_ff <= WDATA_I[7:0];
						kind_ff <= (ADDR_I == A_CMD) ? K_OP : (ADDR_I == A_WDATA) ? K_WR : K_RD;
					end
				end
				H_LOW, H_HIGH: begin
					if (cnt_ff == 3'h0) begin
						st_ff <= (st_ff == H_LOW) ? H_HIGH : H_TAIL;
						clk_ff <= (st_ff == H_LOW);
						cnt_ff <= 3'(LNK_HALF - 1);
					end else begin
						cnt_ff <= cnt_ff - 3'h1;
					end
				end
				H_TAIL: begin
					if (cnt_ff == 3'h0) begin
						st_ff <= H_IDLE;
						kind_ff <= K_IDLE;
						if (kind_ff == K_RD) begin
							rbyte_ff <= rd_s;
						end
					end else begin
						cnt_ff <= cnt_ff - 3'h1;
					end
				end
				default: st_ff <= H_IDLE;
			endcase
		end
	end
	// ==========================================
	// Embedded port emulation
	logic em_wr;
	logic [2:0] ecode;
	logic eset;
	logic [2:0] ests_ff;
	logic [4:0] echg_ff;
	logic ef_en_ff;
	logic addr0_ff;
	logic intdis_ff;
	assign em_wr = WR_I & (ADDR_I == A_EMB);
	assign ecode = WDATA_I[2:0];
	assign eset = WDATA_I[EMB_SET];
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ests_ff <= 3'h1;
			ef_en_ff <= 1'b0;
			addr0_ff <= 1'b0;
			intdis_ff <= 1'b0;
		end else begin
			addr0_ff <= 1'b0;
			if (em_wr && WDATA_I[EMB_BABBLE]) begin
				ests_ff[B_EN] <= 1'b0;
				ef_en_ff <= 1'b0;
			end else if (em_wr) begin
				case ({eset, ecode})
					{1'b1, FEAT_PORT_ENABLE}: begin
						ests_ff[B_EN] <= 1'b1;
						ef_en_ff <= 1'b1;
						intdis_ff <= 1'b0;
					end
					{1'b1, FEAT_PORT_SUSPEND}: begin
						ests_ff[B_EN] <= 1'b0;
						ests_ff[B_SUSP] <= 1'b1;
						ef_en_ff <= 1'b0;
					end
					{1'b1, FEAT_PORT_RESTART}: begin
						ests_ff[B_EN] <= 1'b0;
						ef_en_ff <= 1'b1;
						addr0_ff <= 1'b1;
						intdis_ff <= 1'b1;
					end
					{1'b0, FEAT_PORT_ENABLE}: begin
						ests_ff[B_EN] <= 1'b0;
						ef_en_ff <= 1'b0;
					end
					{1'b0, FEAT_PORT_SUSPEND}: begin
						ests_ff[B_EN] <= 1'b1;
						ests_ff[B_SUSP] <= 1'b0;
						ef_en_ff <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end
	// Change bits: set wins over clear
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			echg_ff <= 5'h0;
		end else if (em_wr) begin
			if (WDATA_I[EMB_BABBLE]) begin
				echg_ff[B_EN] <= 1'b1;
			end else if (eset && ecode == FEAT_PORT_RESTART) begin
				echg_ff[B_RST] <= 1'b1;
			end else if (!eset && ecode == FEAT_PORT_SUSPEND && ests_ff[B_SUSP]) begin
				echg_ff[B_SUSP] <= 1'b1;
			end else if (!eset && ecode == FEAT_PORT_RESTART) begin
				echg_ff[B_RST] <= 1'b0;
			end else if (!eset && ecode[2]) begin
				echg_ff[ecode[1:0]] <= 1'b0;
			end
		end
	end
	// ==========================================
	// Software reads
	logic [15:0] rdata_ff;
	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rdata_ff <= 16'h0000;
		end else if (RD_I) begin
			case (ADDR_I)
				A_RDATA: rdata_ff <= {8'h00, rbyte_ff};
				A_STAT: rdata_ff <= {15'h0000, st_ff != H_IDLE};
				A_EMB: rdata_ff <= {3'h0, echg_ff, 5'h00, ests_ff};
				default: rdata_ff <= 16'h0000;
			endcase
		end else begin
			rdata_ff <= 16'h0000;
		end
	end
	assign RDATA_O = rdata_ff;
	assign EF_EN_O = ef_en_ff;
	assign EF_ADDR0_O = addr0_ff;
	assign INT_EP_DIS_O = intdis_ff;
	assign LNK.clk = clk_ff;
	assign LNK.kind = kind_ff;
	assign LNK.wdata = wd_ff;
endmodule // usbhc_ctl
`default_nettype wire

// ### usbhc_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module usbhc_link_sva
	import usbhc_pkg::*;
(
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RESETN_I,
	// Link
	input wire logic clk,
	input wire logic [1:0] kind,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RESETN_I);
	// ==========================================
	// Link framing
	property p_idle_low; kind == K_IDLE |-> !clk; endproperty
	a_idle_low: assert property (p_idle_low) else $error("link clock moved while idle");
	property p_setup; $rose(clk) |-> kind != K_IDLE && $past(kind, 4) == kind; endproperty
	a_setup: assert property (p_setup) else $error("kind not set up before rise");
	property p_wsetup; $rose(clk) |-> $past(wdata, 4) == wdata; endproperty
	a_wsetup: assert property (p_wsetup) else $error("byte not set up before rise");
	property p_high; $rose(clk) |-> clk[*4] ##1 !clk; endproperty
	a_high: assert property (p_high) else $error("link high phase length wrong");
	property p_kind_hold; clk |-> $stable(kind); endproperty
	a_kind_hold: assert property (p_kind_hold) else $error("kind moved while high");
	property p_data_hold; clk |-> $stable(wdata); endproperty
	a_data_hold: assert property (p_data_hold) else $error("byte moved while high");
	property p_tail; $fell(clk) |=> $stable(kind)[*3]; endproperty
	a_tail: assert property (p_tail) else $error("kind dropped inside tail");
	property p_gap; $fell(clk) |=> !clk[*4]; endproperty
	a_gap: assert property (p_gap) else $error("link low phase too short");
	// Read byte may only move inside a read transfer
	property p_rd_only; $changed(rdata) |-> kind == K_RD; endproperty
	a_rd_only: assert property (p_rd_only) else $error("read byte moved outside read");
	c_op: cover property ($rose(clk) && kind == K_OP);
	c_wr: cover property ($rose(clk) && kind == K_WR);
	c_rd: cover property ($rose(clk) && kind == K_RD);
endmodule // usbhc_link_sva
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import usbhc_pkg::*;
	// ==========================================
	// Signals
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdat = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic setup_rx = 1'b0;
	logic sof_ok = 1'b0;
	logic babble = 1'b0;
	logic mode = 1'b0;
	logic [13:0] out_pkt = 14'h0000;
	logic [13:0] in_sent = 14'h0000;
	logic [10:0] frame = 11'h000;
	logic [1:0] conn = 2'h0;
	logic [1:0] ls = 2'h0;
	logic [1:0] oc = 2'h0;
	logic [15:0] rdat;
	logic ef_en, ef_a0, int_dis, setup_hold, power, resume, ef_dis;
	logic [13:0] buf_full, stall, toggle;
	logic [1:0] port_en, port_susp, port_rst, oc_det;
	logic [3:0] hub_chg;
	int n_fail = 0;
	int checks = 0;
	usbhc_link_if lnk();
	usbhc_dev #(.RST_CYC(20)) usbhc_dev_inst (.CLOCK_I(clock), .RESETN_I(resetn), .LNK(lnk),
		.OUT_PKT_I(out_pkt), .IN_SENT_I(in_sent), .SETUP_RX_I(setup_rx), .SOF_OK_I(sof_ok),
		.FRAME_I(frame), .BABBLE_I(babble), .MODE_I(mode), .CONN_I(conn), .LS_I(ls), .OC_I(oc),
		.BUF_FULL_O(buf_full), .STALL_O(stall), .TOGGLE_O(toggle), .SETUP_HOLD_O(setup_hold),
		.PORT_EN_O(port_en), .PORT_SUSP_O(port_susp), .PORT_RST_O(port_rst), .OC_DET_O(oc_det),
		.POWER_O(power), .RESUME_O(resume), .EF_DIS_O(ef_dis), .HUB_CHG_O(hub_chg));
	usbhc_ctl usbhc_ctl_inst (.CLOCK_I(clock), .RESETN_I(resetn), .ADDR_I(addr), .WDATA_I(wdat),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .EF_EN_O(ef_en), .EF_ADDR0_O(ef_a0),
		.INT_EP_DIS_O(int_dis), .LNK(lnk));
	usbhc_link_sva usbhc_link_sva_inst (.CLOCK_I(clock), .RESETN_I(resetn), .clk(lnk.clk),
		.kind(lnk.kind), .wdata(lnk.wdata), .rdata(lnk.rdata));
	initial begin
		forever #10 clock = ~clock;
	end
	// ==========================================
	// Tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wdat <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdat;
	endtask
	// Busy poll is bounded so a stuck link ends the run
	task automatic idle();
		logic [15:0] s;
		s = 16'h0001;
		for (int i = 0; i < 40 && s[0] !== 1'b0; i++)
			rd_reg(A_STAT, s);
		if (s[0] !== 1'b0) begin
			n_fail++;
			conclude();
		end
	endtask
	task automatic send(input logic [7:0] a, input logic [7:0] b);
		idle();
		wr_reg(a, {8'h00, b});
		idle();
	endtask
	task automatic get(output logic [15:0] d);
		send(A_RDATA, 8'h00);
		rd_reg(A_RDATA, d);
	endtask
	// ==========================================
	// Sequence
	initial begin
		logic [15:0] v;
		int n;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		rd_reg(8'h20, v);
		chk(v, 16'h0000);
		out_pkt <= 14'h0004;
		@(posedge clock);
		out_pkt <= 14'h0000;
		repeat (2) @(posedge clock);
		#1 chk(buf_full, 16'h0004);
		send(A_CMD, 8'h02);
		get(v);
		chk(v, 16'h0001);
		send(A_CMD, OP_CLR_BUF);
		chk(buf_full, 16'h0000);
		$display("buffer test done");
		out_pkt <= 14'h0004;
		@(posedge clock);
		out_pkt <= 14'h0000;
		send(A_CMD, 8'h42);
		send(A_WDATA, 8'h01);
		chk(stall[2], 1'b1);
		send(A_CMD, 8'h42);
		send(A_WDATA, 8'h00);
		chk({stall[2], buf_full[2], toggle[2]}, 16'h0000);
		send(A_CMD, 8'h40);
		send(A_WDATA, 8'h01);
		setup_rx <= 1'b1;
		@(posedge clock);
		setup_rx <= 1'b0;
		repeat (2) @(posedge clock);
		#1 chk({stall[0], setup_hold}, 16'h0001);
		send(A_CMD, 8'h01);
		send(A_CMD, OP_VALIDATE);
		chk(buf_full[1], 1'b0);
		send(A_CMD, OP_ACK_SETUP);
		chk(setup_hold, 1'b1);
		send(A_CMD, 8'h00);
		send(A_CMD, OP_ACK_SETUP);
		chk(setup_hold, 1'b0);
		send(A_CMD, 8'h01);
		send(A_CMD, OP_VALIDATE);
		chk(buf_full[1], 1'b1);
		$display("endpoint test done");
		for (int k = 0; k < 2; k++) begin
			send(A_CMD, 8'hE9);
			send(A_WDATA, 8'h03);
			chk({power, oc_det}, k ? 16'h0007 : 16'h0004);
		end
		send(A_CMD, 8'hE0);
		send(A_WDATA, 8'h03);
		chk({power, oc_det}, 16'h0000);
		mode <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			send(A_CMD, 8'hE9);
			send(A_WDATA, 8'h03);
		end
		chk({power, oc_det}, 16'h0006);
		send(A_CMD, 8'hE1);
		send(A_WDATA, 8'h03);
		$display("power test done");
		conn <= 2'h1;
		send(A_CMD, 8'hE8);
		send(A_WDATA, {5'h00, FEAT_PORT_RESTART});
		chk(port_rst, 16'h0001);
		n = 0;
		while (port_rst[0] !== 1'b0 && n < 60) begin
			@(posedge clock);
			n++;
		end
		chk(port_rst, 16'h0000);
		send(A_CMD, 8'hE0);
		get(v);
		chk(v, 16'h0003);
		get(v);
		chk(v, 16'h0011);
		send(A_CMD, 8'hE0);
		send(A_WDATA, 8'h04);
		send(A_CMD, 8'hE0);
		get(v);
		get(v);
		chk(v, 16'h0010);
		send(A_CMD, 8'hE8);
		send(A_WDATA, 8'h01);
		chk(port_susp, 16'h0001);
		send(A_CMD, 8'hE0);
		send(A_WDATA, 8'h01);
		chk(port_susp, 16'h0000);
		$display("port test done");
		frame <= 11'h5A3;
		sof_ok <= 1'b1;
		@(posedge clock);
		sof_ok <= 1'b0;
		send(A_CMD, OP_FRAME);
		get(v);
		chk(v, 16'h00A3);
		get(v);
		chk(v, 16'h0005);
		idle();
		wr_reg(A_CMD, {8'h00, OP_RESUME});
		n = 0;
		for (int k = 0; k < 60; k++) begin
			@(posedge clock);
			#1 n += (resume === 1'b1);
		end
		chk(n[15:0], 16'h0014);
		babble <= 1'b1;
		@(posedge clock);
		babble <= 1'b0;
		repeat (2) @(posedge clock);
		#1 chk(ef_dis, 1'b1);
		send(A_CMD, OP_CHG_BITS);
		send(A_WDATA, 8'h03);
		chk({ef_dis, hub_chg[1:0]}, 16'h0003);
		$display("hub test done");
		wr_reg(A_EMB, 16'h000A);
		#1 chk(ef_a0, 1'b1);
		rd_reg(A_EMB, v);
		chk({ef_en, int_dis, v[12], v[1]}, 16'h000E);
		wr_reg(A_EMB, 16'h0010);
		rd_reg(A_EMB, v);
		chk({v[9], v[1]}, 16'h0002);
		$display("embedded test done");
		conclude();
	end
endmodule // testbench
`default_nettype wire
